// ### core/route_pkg.sv
// Constants, register map and types for the port routing-decode block.
// Assumes a 32-bit register port with byte offsets on word boundaries.
package route_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int FUNC_W = 8;
  localparam int NFUNC = 256;
  localparam int FGRP_W = 3;
  localparam int MAX_FGROUPS = 8;
  localparam int GROUP_W = 6;
  localparam int NGROUP = 64;
  localparam int PADDR_W = 64;
  localparam int LEGACY_FN_W = 3;
  localparam int DEV_LSB = 3;
  localparam int DEV_W = 5;
  localparam int TAG_CNT_W = 9;
  localparam logic [TAG_CNT_W-1:0] TAG_LIMIT_BASE = 9'h020;
  localparam logic [TAG_CNT_W-1:0] TAG_LIMIT_EXT = 9'h100;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_BASE_LO = 8'h04;
  localparam logic [ADDR_W-1:0] REG_BASE_HI = 8'h08;
  localparam logic [ADDR_W-1:0] REG_BLK_ALL_LO = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_BLK_ALL_HI = 8'h10;
  localparam logic [ADDR_W-1:0] REG_BLK_UNX_LO = 8'h14;
  localparam logic [ADDR_W-1:0] REG_BLK_UNX_HI = 8'h18;
  localparam logic [ADDR_W-1:0] REG_PORT_SEL = 8'h1c;
  localparam logic [ADDR_W-1:0] REG_FWD_LO = 8'h20;
  localparam logic [ADDR_W-1:0] REG_FWD_HI = 8'h24;
  localparam logic [ADDR_W-1:0] REG_CAPS = 8'h28;
  localparam logic [ADDR_W-1:0] REG_FUNC_SEL = 8'h2c;
  localparam logic [ADDR_W-1:0] REG_FUNC_CFG = 8'h30;
  localparam logic [ADDR_W-1:0] REG_SLOT_SEL = 8'h34;
  localparam logic [ADDR_W-1:0] REG_SLOT_VAL = 8'h38;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h3c;
  localparam logic [ADDR_W-1:0] REG_BUS_RANGE = 8'h40;
  localparam logic [ADDR_W-1:0] REG_EGRESS_VEC = 8'h44;
  localparam logic [ADDR_W-1:0] REG_TAG_STAT = 8'h48;

  // Control register fields
  localparam int CTRL_MC_EN = 0;
  localparam int CTRL_FWD_ON = 1;
  localparam int CTRL_WIDE = 2;
  localparam int CTRL_GRP_EGR = 3;
  localparam int CTRL_GRP_ARB = 4;
  localparam int CTRL_EXT_TAG = 5;
  localparam int CTRL_SRC_VAL = 6;
  localparam int CTRL_REDIR = 7;
  localparam int CTRL_NGRP_LSB = 8;
  localparam int CTRL_SHIFT_LSB = 16;
  localparam logic [DATA_W-1:0] CTRL_RST = 32'h0000_0000;

  // Capability register fields
  localparam int CAP_FWD_SUP = 0;
  localparam int CAP_WIDE = 1;
  localparam int CAP_PHANTOM_LSB = 2;
  localparam int CAP_EXT_TAG = 4;
  localparam logic [1:0] PHANTOM_NONE = 2'h0;

  // Function config fields
  localparam int FCFG_GRP_LSB = 0;
  localparam int FCFG_NEXT_LSB = 8;
  localparam int FCFG_PRESENT = 16;

  // Sticky status bits, write one to clear
  localparam int ST_TGT_ABORT = 0;
  localparam int ST_BLOCKED = 1;
  localparam int ST_SILENT = 2;
  localparam int ST_SRC_VIOL = 3;
  localparam int ST_W = 4;

  localparam int BUS_SUB_LSB = 8;

  typedef enum logic [1:0] {
    KIND_MEM_WR,
    KIND_ADDR_MSG,
    KIND_MEM_NP,
    KIND_OTHER
  } pkt_kind_t;
endpackage

// ### core/port_route.sv
// Routing-id interpretation, function groups and replication decode for one port.
// Assumes packet and config inputs are synchronous to clk and held for one cycle.
// What this block does
// [RQ1] Wide numbering reads routing id as 8-bit bus plus 8-bit function.
// [RQ2] With forwarding on, Type 1 to Type 0 ignores device number.
// [RQ3] With forwarding off, conversion only when device number is zero.
// [RQ4] Functions above seven are always enabled, no enable control.
// [RQ5] Capability bits advertise wide-id forwarding and wide numbering.
// [RQ6] Each function holds a function group number, eight groups maximum.
// [RQ7] Arbitration slots hold group numbers in group mode.
// [RQ8] Function within winning group chosen by lowest requesting index.
// [RQ9] Egress control may index by function group instead of function.
// [RQ10] Each function shows next function number; function zero heads list.
// [RQ11] Phantom functions field always reads 00b.
// [RQ12] Extended tag enable allows up to 256 outstanding requests.
// [RQ13] Replication range split into equal windows, group field at shift.
// [RQ14] Hit needs enable, posted kind, address inside replication range.
// [RQ15] One shared set of replication settings used for all functions.
// [RQ16] Non-posted request in window is no hit, routed unicast.
// [RQ17] On hit only source validation applies; redirect and egress ignored.
// [RQ18] Hit bypasses normal routing; group taken from address.
// [RQ19] Group is address minus base, shifted right, low six bits.
// [RQ20] Block checks applied at ingress or before sending, local masks.
// [RQ21] Block-every bit for group blocks the packet.
// [RQ22] Block-untranslated bit blocks packets with untranslated address.
// [RQ23] Blocked packet dropped, error signalled, target abort status set.
// [RQ24] Unblocked hit forwarded to masked ports except ingress, else dropped.
//
// The placing of the registers and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
module port_route
  import route_pkg::*;
#(
  parameter int NPORTS = 4,
  parameter int NARB = 16,
  parameter int NSLOTS = 32,
  parameter bit IS_SWITCH = 1'b1,
  parameter bit FWD_SUPPORTED = 1'b1,
  parameter logic [NFUNC-1:0] FUNC_MAP = 256'hffff,
  parameter int PW = (NPORTS > 1) ? $clog2(NPORTS) : 1,
  parameter int SW = (NSLOTS > 1) ? $clog2(NSLOTS) : 1
) (
  // Clock and reset
  input logic clk,
  input logic rstn,
  // Register port
  input logic [ADDR_W-1:0] reg_addr,
  input logic [DATA_W-1:0] reg_wdata,
  input logic reg_wr,
  input logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  // Configuration request decode
  input logic cfg_valid,
  input logic cfg_type1,
  input logic [7:0] cfg_bus,
  input logic [7:0] cfg_id_low,
  output logic cfg_done,
  output logic cfg_to_type0,
  output logic cfg_pass_type1,
  output logic cfg_unsupported,
  output logic cfg_local,
  output logic [FUNC_W-1:0] cfg_func,
  output logic cfg_func_exists,
  // Function arbitration
  input logic arb_step,
  input logic [NARB-1:0] arb_req,
  output logic arb_valid,
  output logic [NARB-1:0] arb_grant,
  // Outstanding tags
  input logic tag_alloc,
  input logic tag_free,
  output logic tag_avail,
  // Packet decode
  input logic pkt_valid,
  input pkt_kind_t pkt_kind,
  input logic [PADDR_W-1:0] pkt_addr,
  input logic pkt_untranslated,
  input logic [7:0] pkt_req_bus,
  input logic [FUNC_W-1:0] pkt_dst_func,
  input logic [PW-1:0] pkt_ingress,
  // Packet result
  output logic res_valid,
  output logic res_hit,
  output logic [GROUP_W-1:0] res_group,
  output logic res_blocked,
  output logic [NPORTS-1:0] res_fwd_ports,
  output logic res_silent_drop,
  output logic res_unicast,
  output logic res_src_violation,
  output logic res_redirect,
  output logic res_egress_blocked
);

  logic [DATA_W-1:0] ctrl_r;
  logic [PADDR_W-1:0] base_r;
  logic [NGROUP-1:0] blk_all_r;
  logic [NGROUP-1:0] blk_unx_r;
  logic [NGROUP-1:0] fwd_mask_r [NPORTS];
  logic [PW-1:0] port_sel_r;
  logic [FUNC_W-1:0] func_sel_r;
  logic [FGRP_W-1:0] func_group_r [NFUNC];
  logic [SW-1:0] slot_sel_r;
  logic [FUNC_W-1:0] slot_tab_r [NSLOTS];
  logic [SW-1:0] slot_ptr_r;
  logic [ST_W-1:0] status_r;
  logic [7:0] sec_bus_r;
  logic [7:0] sub_bus_r;
  logic [DATA_W-1:0] egress_vec_r;
  logic [TAG_CNT_W-1:0] tag_cnt_r;
  logic [DATA_W-1:0] rd_nxt;
  logic [DATA_W-1:0] rdata_r;

  logic mc_en;
  logic fwd_on;
  logic wide;
  logic [GROUP_W-1:0] ngrp_m1;
  logic [GROUP_W-1:0] shift;
  logic wr_ctrl;

  assign mc_en = ctrl_r[CTRL_MC_EN];
  assign fwd_on = ctrl_r[CTRL_FWD_ON];
  assign wide = ctrl_r[CTRL_WIDE];
  assign ngrp_m1 = ctrl_r[CTRL_NGRP_LSB +: GROUP_W];
  assign shift = ctrl_r[CTRL_SHIFT_LSB +: GROUP_W];
  assign wr_ctrl = reg_wr && (reg_addr == REG_CTRL);

  // Control and single shared replication settings
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_r <= CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_r <= reg_wdata; // RQ15
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      base_r <= '0;
      blk_all_r <= '0;
      blk_unx_r <= '0;
      sec_bus_r <= '0;
      sub_bus_r <= '0;
      egress_vec_r <= '0;
    end else if (reg_wr) begin
      unique case (reg_addr)
        REG_BASE_LO: base_r[31:0] <= reg_wdata;
        REG_BASE_HI: base_r[63:32] <= reg_wdata;
        REG_BLK_ALL_LO: blk_all_r[31:0] <= reg_wdata;
        REG_BLK_ALL_HI: blk_all_r[63:32] <= reg_wdata;
        REG_BLK_UNX_LO: blk_unx_r[31:0] <= reg_wdata;
        REG_BLK_UNX_HI: blk_unx_r[63:32] <= reg_wdata;
        REG_BUS_RANGE: begin
          sec_bus_r <= reg_wdata[7:0];
          sub_bus_r <= reg_wdata[BUS_SUB_LSB +: 8];
        end
        REG_EGRESS_VEC: egress_vec_r <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Index selectors
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      port_sel_r <= '0;
      func_sel_r <= '0;
      slot_sel_r <= '0;
    end else if (reg_wr) begin
      if (reg_addr == REG_PORT_SEL) begin
        port_sel_r <= reg_wdata[PW-1:0];
      end
      if (reg_addr == REG_FUNC_SEL) begin
        func_sel_r <= reg_wdata[FUNC_W-1:0];
      end
      if (reg_addr == REG_SLOT_SEL) begin
        slot_sel_r <= reg_wdata[SW-1:0];
      end
    end
  end

  // Per-port forward masks
  generate
    for (genvar p = 0; p < NPORTS; p++) begin : g_fwd
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          fwd_mask_r[p] <= '0;
        end else if (reg_wr && port_sel_r == PW'(p)) begin
          if (reg_addr == REG_FWD_LO) begin
            fwd_mask_r[p][31:0] <= reg_wdata;
          end else if (reg_addr == REG_FWD_HI) begin
            fwd_mask_r[p][63:32] <= reg_wdata;
          end
        end
      end
    end
  endgenerate

  // Function group numbers, one per function
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int f = 0; f < NFUNC; f++) begin
        func_group_r[f] <= '0;
      end
    end else if (reg_wr && reg_addr == REG_FUNC_CFG) begin
      func_group_r[func_sel_r] <= reg_wdata[FCFG_GRP_LSB +: FGRP_W]; // RQ6
    end
  end

  // Arbitration table
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int s = 0; s < NSLOTS; s++) begin
        slot_tab_r[s] <= '0;
      end
    end else if (reg_wr && reg_addr == REG_SLOT_VAL) begin
      slot_tab_r[slot_sel_r] <= reg_wdata[FUNC_W-1:0];
    end
  end

  // Next implemented function above the selected one, zero ends the list
  logic [FUNC_W-1:0] next_func;
  logic next_found;
  always_comb begin
    next_func = '0;
    next_found = 1'b0;
    for (int j = 1; j < NFUNC; j++) begin
      if (!next_found && j > int'(func_sel_r) && FUNC_MAP[j]) begin
        next_func = FUNC_W'(j); // RQ10
        next_found = 1'b1;
      end
    end
  end

  // Configuration request decode
  logic [DEV_W-1:0] cfg_dev;
  logic [FUNC_W-1:0] cfg_fn;
  logic to_sec;
  logic below_sec;
  assign cfg_dev = cfg_id_low[DEV_LSB +: DEV_W];
  assign cfg_fn = wide ? cfg_id_low : {{(FUNC_W-LEGACY_FN_W){1'b0}}, cfg_id_low[LEGACY_FN_W-1:0]}; // RQ1
  assign to_sec = cfg_bus == sec_bus_r;
  assign below_sec = (cfg_bus > sec_bus_r) && (cfg_bus <= sub_bus_r);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfg_done <= 1'b0;
      cfg_to_type0 <= 1'b0;
      cfg_pass_type1 <= 1'b0;
      cfg_unsupported <= 1'b0;
      cfg_local <= 1'b0;
      cfg_func <= '0;
      cfg_func_exists <= 1'b0;
    end else begin
      cfg_done <= cfg_valid;
      cfg_to_type0 <= cfg_valid && cfg_type1 && to_sec && (fwd_on || cfg_dev == '0); // RQ2 RQ3
      cfg_pass_type1 <= cfg_valid && cfg_type1 && below_sec;
      cfg_unsupported <= cfg_valid && cfg_type1 && ((to_sec && !fwd_on && cfg_dev != '0) || (!to_sec && !below_sec));
      cfg_local <= cfg_valid && !cfg_type1;
      cfg_func <= cfg_fn;
      // Existence depends only on implementation, no per-function enable
      cfg_func_exists <= cfg_valid && !cfg_type1 && FUNC_MAP[cfg_fn]; // RQ4
    end
  end

  // Function arbitration over the slot table
  logic [FUNC_W-1:0] slot_ent;
  logic [NARB-1:0] grant_nxt;
  logic grant_found;
  assign slot_ent = slot_tab_r[slot_ptr_r];
  always_comb begin
    grant_nxt = '0;
    grant_found = 1'b0;
    for (int i = 0; i < NARB; i++) begin
      if (!grant_found && arb_req[i]) begin
        if (ctrl_r[CTRL_GRP_ARB]) begin
          if (func_group_r[i] == slot_ent[FGRP_W-1:0]) begin // RQ7
            grant_nxt[i] = 1'b1; // RQ8
            grant_found = 1'b1;
          end
        end else if (slot_ent == FUNC_W'(i)) begin
          grant_nxt[i] = 1'b1;
          grant_found = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      slot_ptr_r <= '0;
      arb_valid <= 1'b0;
      arb_grant <= '0;
    end else begin
      arb_valid <= arb_step && grant_found;
      arb_grant <= arb_step ? grant_nxt : '0;
      if (arb_step) begin
        slot_ptr_r <= (slot_ptr_r == SW'(NSLOTS - 1)) ? '0 : slot_ptr_r + 1'b1;
      end
    end
  end

  // Outstanding tag count
  logic [TAG_CNT_W-1:0] tag_limit;
  logic tag_take;
  logic tag_give;
  assign tag_limit = ctrl_r[CTRL_EXT_TAG] ? TAG_LIMIT_EXT : TAG_LIMIT_BASE; // RQ12
  assign tag_avail = tag_cnt_r < tag_limit;
  assign tag_take = tag_alloc && tag_avail;
  assign tag_give = tag_free && (tag_cnt_r != '0);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tag_cnt_r <= '0;
    end else if (tag_take && !tag_give) begin
      tag_cnt_r <= tag_cnt_r + 1'b1;
    end else if (tag_give && !tag_take) begin
      tag_cnt_r <= tag_cnt_r - 1'b1;
    end
  end

  // Replication window decode
  logic [PADDR_W:0] offs;
  logic [PADDR_W:0] win_idx;
  logic in_range;
  logic posted;
  logic hit;
  logic [GROUP_W-1:0] grp;
  logic blocked;
  logic src_bad;
  logic egr_bit;
  logic [FGRP_W-1:0] dst_fgrp;
  logic [NPORTS-1:0] fwd_nxt;

  assign offs = {1'b0, pkt_addr} - {1'b0, base_r};
  assign win_idx = offs >> shift; // RQ13
  // Compare window index to group count; avoids overflow of base plus size
  assign in_range = !offs[PADDR_W] && (win_idx <= (PADDR_W+1)'(ngrp_m1));
  assign posted = (pkt_kind == KIND_MEM_WR) || (pkt_kind == KIND_ADDR_MSG);
  assign hit = mc_en && posted && in_range; // RQ14 RQ16
  assign grp = win_idx[GROUP_W-1:0]; // RQ18 RQ19
  assign blocked = hit && (blk_all_r[grp] || (blk_unx_r[grp] && pkt_untranslated)); // RQ20 RQ21 RQ22
  assign src_bad = ctrl_r[CTRL_SRC_VAL] && ((pkt_req_bus < sec_bus_r) || (pkt_req_bus > sub_bus_r));
  assign dst_fgrp = func_group_r[pkt_dst_func];
  assign egr_bit = ctrl_r[CTRL_GRP_EGR] ? egress_vec_r[dst_fgrp] : egress_vec_r[pkt_dst_func[4:0]]; // RQ9

  generate
    for (genvar p = 0; p < NPORTS; p++) begin : g_out
      assign fwd_nxt[p] = fwd_mask_r[p][grp] && !(IS_SWITCH && pkt_ingress == PW'(p)); // RQ24
    end
  endgenerate

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      res_valid <= 1'b0;
      res_hit <= 1'b0;
      res_group <= '0;
      res_blocked <= 1'b0;
      res_fwd_ports <= '0;
      res_silent_drop <= 1'b0;
      res_unicast <= 1'b0;
      res_src_violation <= 1'b0;
      res_redirect <= 1'b0;
      res_egress_blocked <= 1'b0;
    end else begin
      res_valid <= pkt_valid;
      res_hit <= pkt_valid && hit;
      res_group <= hit ? grp : '0;
      res_blocked <= pkt_valid && blocked; // RQ23
      res_fwd_ports <= (pkt_valid && hit && !blocked) ? fwd_nxt : '0; // RQ24
      res_silent_drop <= pkt_valid && hit && !blocked && (fwd_nxt == '0);
      res_unicast <= pkt_valid && !hit; // RQ16
      res_src_violation <= pkt_valid && src_bad; // RQ17
      res_redirect <= pkt_valid && !hit && ctrl_r[CTRL_REDIR] && !src_bad; // RQ17
      res_egress_blocked <= pkt_valid && !hit && egr_bit; // RQ17
    end
  end

  // Sticky status; a new event beats a clear in the same cycle
  logic [ST_W-1:0] st_set;
  logic [ST_W-1:0] st_clr;
  assign st_set[ST_TGT_ABORT] = pkt_valid && blocked; // RQ23
  assign st_set[ST_BLOCKED] = pkt_valid && blocked;
  assign st_set[ST_SILENT] = pkt_valid && hit && !blocked && (fwd_nxt == '0);
  assign st_set[ST_SRC_VIOL] = pkt_valid && src_bad;
  assign st_clr = (reg_wr && reg_addr == REG_STATUS) ? reg_wdata[ST_W-1:0] : '0;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      status_r <= '0;
    end else begin
      status_r <= (status_r & ~st_clr) | st_set;
    end
  end

  // Read mux
  logic [DATA_W-1:0] caps;
  logic [DATA_W-1:0] fcfg;
  always_comb begin
    caps = '0;
    caps[CAP_FWD_SUP] = FWD_SUPPORTED; // RQ5
    caps[CAP_WIDE] = 1'b1; // RQ5
    caps[CAP_PHANTOM_LSB +: 2] = PHANTOM_NONE; // RQ11
    caps[CAP_EXT_TAG] = 1'b1;
    fcfg = '0;
    fcfg[FCFG_GRP_LSB +: FGRP_W] = func_group_r[func_sel_r];
    fcfg[FCFG_NEXT_LSB +: FUNC_W] = next_func; // RQ10
    fcfg[FCFG_PRESENT] = FUNC_MAP[func_sel_r];
    rd_nxt = '0;
    unique case (reg_addr)
      REG_CTRL: rd_nxt = ctrl_r;
      REG_BASE_LO: rd_nxt = base_r[31:0];
      REG_BASE_HI: rd_nxt = base_r[63:32];
      REG_BLK_ALL_LO: rd_nxt = blk_all_r[31:0];
      REG_BLK_ALL_HI: rd_nxt = blk_all_r[63:32];
      REG_BLK_UNX_LO: rd_nxt = blk_unx_r[31:0];
      REG_BLK_UNX_HI: rd_nxt = blk_unx_r[63:32];
      REG_PORT_SEL: rd_nxt = DATA_W'(port_sel_r);
      REG_FWD_LO: rd_nxt = fwd_mask_r[port_sel_r][31:0];
      REG_FWD_HI: rd_nxt = fwd_mask_r[port_sel_r][63:32];
      REG_CAPS: rd_nxt = caps;
      REG_FUNC_SEL: rd_nxt = DATA_W'(func_sel_r);
      REG_FUNC_CFG: rd_nxt = fcfg;
      REG_SLOT_SEL: rd_nxt = DATA_W'(slot_sel_r);
      REG_SLOT_VAL: rd_nxt = DATA_W'(slot_tab_r[slot_sel_r]);
      REG_STATUS: rd_nxt = DATA_W'(status_r);
      REG_BUS_RANGE: rd_nxt = {16'h0000, sub_bus_r, sec_bus_r};
      REG_EGRESS_VEC: rd_nxt = egress_vec_r;
      REG_TAG_STAT: rd_nxt = DATA_W'(tag_cnt_r);
      default: rd_nxt = '0;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= reg_rd ? rd_nxt : '0;
    end
  end

  assign reg_rdata = rdata_r;

endmodule

// ### sim/port_route_chk.sv
// Port-level checks on config, arbiter and replication results.
// Assumes binding to port_route; one clock domain.
`timescale 1ns/1ps
module port_route_chk
  import route_pkg::*;
#(
  parameter int NPORTS = 4,
  parameter int NARB = 16,
  parameter int PW = 2
) (
  // Clock and reset
  input logic clk,
  input logic rstn,
  // Config decode
  input logic cfg_valid,
  input logic cfg_type1,
  input logic cfg_done,
  input logic cfg_to_type0,
  input logic cfg_pass_type1,
  input logic cfg_unsupported,
  input logic cfg_local,
  // Arbiter
  input logic arb_step,
  input logic arb_valid,
  input logic [NARB-1:0] arb_grant,
  // Packets
  input logic pkt_valid,
  input pkt_kind_t pkt_kind,
  input logic [PW-1:0] pkt_ingress,
  input logic res_valid,
  input logic res_hit,
  input logic [GROUP_W-1:0] res_group,
  input logic res_blocked,
  input logic [NPORTS-1:0] res_fwd_ports,
  input logic res_silent_drop,
  input logic res_unicast,
  input logic res_redirect,
  input logic res_egress_blocked
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  a_res_latency: assert property (res_valid == $past(pkt_valid))
    else $error("result valid late");
  a_nonposted_miss: assert property (pkt_valid && !(pkt_kind inside {KIND_MEM_WR, KIND_ADDR_MSG}) |=> !res_hit && res_unicast)
    else $error("non-posted hit");
  a_unicast_inv: assert property (res_valid |-> res_unicast == !res_hit)
    else $error("unicast not inverse of hit");
  a_hit_no_acs: assert property (res_hit |-> !res_redirect && !res_egress_blocked)
    else $error("access control on hit");
  a_block_drops: assert property (res_blocked |-> res_hit && res_fwd_ports == '0 && !res_silent_drop)
    else $error("blocked packet forwarded");
  a_silent_drop: assert property (res_valid && res_hit && !res_blocked |-> res_silent_drop == (res_fwd_ports == '0))
    else $error("silent drop flag wrong");
  a_no_ingress: assert property (pkt_valid |=> res_fwd_ports[$past(pkt_ingress)] == 1'b0)
    else $error("sent out ingress port");
  a_group_nohit: assert property (res_valid && !res_hit |-> res_group == '0 && !res_blocked)
    else $error("group or block on a miss");
  a_cfg_onehot: assert property (cfg_valid |=> cfg_done && $onehot({cfg_to_type0, cfg_pass_type1, cfg_unsupported, cfg_local}))
    else $error("config outcome not exactly one");
  a_cfg_local: assert property (cfg_valid && !cfg_type1 |=> cfg_local)
    else $error("type 0 request not local");
  a_arb_grant: assert property (!arb_step |=> !arb_valid && arb_grant == '0)
    else $error("grant without arbitration step");
  a_arb_onehot: assert property (arb_valid |-> $onehot(arb_grant))
    else $error("grant not one-hot");
endmodule

// ### sim/link_peer.sv
// Far-side packet source feeding the port's packet inputs.
// Assumes send is called from one thread; one packet per call.
`timescale 1ns/1ps
module link_peer
  import route_pkg::*;
#(
  parameter int PW = 2
) (
  // Clock
  input logic clk,
  // Packet towards the port
  output logic pkt_valid,
  output pkt_kind_t pkt_kind,
  output logic [PADDR_W-1:0] pkt_addr,
  output logic pkt_untranslated,
  output logic [7:0] pkt_req_bus,
  output logic [FUNC_W-1:0] pkt_dst_func,
  output logic [PW-1:0] pkt_ingress
);
  initial begin
    pkt_valid = 1'b0;
    pkt_kind = KIND_OTHER;
    pkt_addr = '0;
    pkt_untranslated = 1'b0;
    pkt_req_bus = 8'h00;
    pkt_dst_func = 8'h00;
    pkt_ingress = '0;
  end
  task automatic send(input pkt_kind_t k, input logic [PADDR_W-1:0] a, input logic u, input logic [PW-1:0] ing);
    @(posedge clk);
    pkt_valid <= 1'b1;
    pkt_kind <= k;
    pkt_addr <= a;
    pkt_untranslated <= u;
    pkt_ingress <= ing;
    pkt_req_bus <= 8'h06;
    pkt_dst_func <= 8'h00;
    @(posedge clk);
    pkt_valid <= 1'b0;
    // Idle lines must not look like the last packet
    pkt_addr <= ~a;
    pkt_untranslated <= ~u;
  endtask
endmodule

// ### sim/port_route_tb_top.sv
// Bench for port_route: registers, config decode, arbiter, tags and replication.
// Assumes link_peer drives packets and port_route_chk is bound at the foot.
`timescale 1ns/1ps
module port_route_tb_top;
  import route_pkg::*;
  localparam logic [63:0] B = 64'h0010_0000;
  logic clk, rstn, reg_wr, reg_rd, cfg_valid, cfg_type1, cfg_done, cfg_to_type0, cfg_pass_type1;
  logic cfg_unsupported, cfg_local, cfg_func_exists, arb_step, arb_valid, tag_alloc, tag_free, tag_avail;
  logic [7:0] reg_addr, cfg_bus, cfg_id_low, cfg_func, pkt_req_bus, pkt_dst_func;
  logic [31:0] reg_wdata, reg_rdata;
  logic [15:0] arb_req, arb_grant;
  logic pkt_valid, pkt_untranslated, res_valid, res_hit, res_blocked, res_silent_drop, res_unicast;
  logic res_src_violation, res_redirect, res_egress_blocked;
  pkt_kind_t pkt_kind;
  logic [63:0] pkt_addr;
  logic [1:0] pkt_ingress;
  logic [5:0] res_group;
  logic [3:0] res_fwd_ports;
  logic [31:0] fwd_m [4] = '{32'h1, 32'h3, 32'h2, 32'h0};
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;
  logic exp_src = 1'b0;

  port_route #(.NPORTS(4)) port_route_i (.*);

  link_peer #(.PW(2)) link_peer_i (.*);

  task automatic conclude();
    if (error_cnt == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  // Expected flags: to_type0, pass_type1, unsupported, local, exists
  task automatic cfg(input logic t1, input logic [7:0] b, input logic [7:0] id, input logic [4:0] e,
                     input logic [7:0] f);
    @(posedge clk);
    cfg_valid <= 1'b1;
    cfg_type1 <= t1;
    cfg_bus <= b;
    cfg_id_low <= id;
    @(posedge clk);
    cfg_valid <= 1'b0;
    #1 chk({cfg_done, cfg_to_type0, cfg_pass_type1, cfg_unsupported, cfg_local, cfg_func_exists, cfg_func},
           {1'b1, e, f});
  endtask
  task automatic arb(input logic [15:0] rq, input logic [15:0] g);
    @(posedge clk);
    arb_step <= 1'b1;
    arb_req <= rq;
    @(posedge clk);
    arb_step <= 1'b0;
    #1 chk({arb_valid, arb_grant}, {1'b1, g});
  endtask
  // Misses expect redirect and egress block, as both are enabled
  task automatic pkt(input pkt_kind_t k, input logic [63:0] a, input logic u, input logic [1:0] ing,
                     input logic h, input logic [5:0] g, input logic b, input logic [3:0] fp);
    link_peer_i.send(k, a, u, ing);
    #1 chk({res_valid, res_hit, res_group, res_blocked, res_fwd_ports, res_silent_drop, res_unicast, res_redirect,
            res_egress_blocked, res_src_violation}, {1'b1, h, g, b, fp, h && !b && fp == 4'h0, !h, !h, !h, exp_src});
  endtask

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      conclude();
    end
  end

  initial begin
    {rstn, reg_wr, reg_rd, cfg_valid, cfg_type1, arb_step, tag_alloc, tag_free} = '0;
    {reg_addr, reg_wdata, cfg_bus, cfg_id_low, arb_req} = '0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    rd(REG_CAPS, 32'h0000_0013);
    rd(REG_CTRL, CTRL_RST);
    rd(8'h80, 32'h0);
    wr(REG_BUS_RANGE, 32'h0000_0805);
    cfg(1'b1, 8'h05, 8'h08, 5'b00100, 8'h00);
    cfg(1'b1, 8'h05, 8'h02, 5'b10000, 8'h02);
    wr(REG_CTRL, 32'h2);
    cfg(1'b1, 8'h05, 8'h08, 5'b10000, 8'h00);
    cfg(1'b1, 8'h07, 8'h08, 5'b01000, 8'h00);
    cfg(1'b1, 8'h09, 8'h08, 5'b00100, 8'h00);
    cfg(1'b0, 8'h00, 8'h0c, 5'b00011, 8'h04);
    wr(REG_CTRL, 32'h6);
    cfg(1'b0, 8'h00, 8'h0c, 5'b00011, 8'h0c);
    cfg(1'b0, 8'h00, 8'h20, 5'b00010, 8'h20);
    wr(REG_FUNC_SEL, 32'h0);
    rd(REG_FUNC_CFG, 32'h0001_0100);
    wr(REG_FUNC_SEL, 32'hf);
    rd(REG_FUNC_CFG, 32'h0001_0000);
    wr(REG_FUNC_SEL, 32'h1);
    wr(REG_FUNC_CFG, 32'hffff_ffff);
    rd(REG_FUNC_CFG, 32'h0001_0207);
    wr(REG_CTRL, 32'h16);
    wr(REG_SLOT_SEL, 32'h0);
    wr(REG_SLOT_VAL, 32'h7);
    wr(REG_SLOT_SEL, 32'h1);
    wr(REG_SLOT_VAL, 32'h2);
    arb(16'h0006, 16'h0002);
    wr(REG_CTRL, 32'h6);
    arb(16'h0006, 16'h0004);
    @(posedge clk);
    tag_alloc <= 1'b1;
    repeat (32) @(posedge clk);
    tag_alloc <= 1'b0;
    #1 chk(tag_avail, 1'b0);
    wr(REG_CTRL, 32'h26);
    #1 chk(tag_avail, 1'b1);
    rd(REG_TAG_STAT, 32'h20);
    @(posedge clk);
    tag_free <= 1'b1;
    repeat (32) @(posedge clk);
    tag_free <= 1'b0;
    wr(REG_BASE_LO, B[31:0]);
    wr(REG_BASE_HI, B[63:32]);
    wr(REG_BLK_ALL_LO, 32'h4);
    wr(REG_BLK_UNX_LO, 32'h2);
    wr(REG_EGRESS_VEC, 32'hffff_ffff);
    for (int p = 0; p < 4; p++) begin
      wr(REG_PORT_SEL, 32'(p));
      wr(REG_FWD_LO, fwd_m[p]);
    end
    wr(REG_CTRL, 32'h000c_0386);
    pkt(KIND_MEM_WR, B, 1'b0, 2'd0, 1'b0, 6'd0, 1'b0, 4'h0);
    wr(REG_CTRL, 32'h000c_0387);
    pkt(KIND_MEM_WR, B, 1'b0, 2'd0, 1'b1, 6'd0, 1'b0, 4'h2);
    pkt(KIND_ADDR_MSG, B + 64'h1010, 1'b0, 2'd1, 1'b1, 6'd1, 1'b0, 4'h4);
    pkt(KIND_MEM_WR, B + 64'h1000, 1'b1, 2'd1, 1'b1, 6'd1, 1'b1, 4'h0);
    pkt(KIND_MEM_WR, B + 64'h2000, 1'b0, 2'd0, 1'b1, 6'd2, 1'b1, 4'h0);
    pkt(KIND_MEM_WR, B + 64'h3fff, 1'b0, 2'd0, 1'b1, 6'd3, 1'b0, 4'h0);
    pkt(KIND_MEM_WR, B + 64'h4000, 1'b0, 2'd0, 1'b0, 6'd0, 1'b0, 4'h0);
    pkt(KIND_MEM_WR, B - 64'h1, 1'b0, 2'd0, 1'b0, 6'd0, 1'b0, 4'h0);
    pkt(KIND_MEM_NP, B + 64'h1000, 1'b0, 2'd0, 1'b0, 6'd0, 1'b0, 4'h0);
    pkt(KIND_OTHER, B, 1'b0, 2'd0, 1'b0, 6'd0, 1'b0, 4'h0);
    wr(REG_BUS_RANGE, 32'h0000_0807);
    wr(REG_CTRL, 32'h000c_03c7);
    exp_src = 1'b1;
    pkt(KIND_MEM_WR, B, 1'b0, 2'd0, 1'b1, 6'd0, 1'b0, 4'h2);
    rd(REG_STATUS, 32'hf);
    wr(REG_STATUS, 32'hf);
    rd(REG_STATUS, 32'h0);
    conclude();
  end
endmodule

bind port_route port_route_chk #(.NPORTS(NPORTS), .NARB(NARB), .PW(PW)) port_route_chk_i (.*);
